/* File: rtl/ssf_pkg.sv */
// constants and field layout for the serial status flag block
// Function
// - tx empty flag sets on reset, standby, tx disable, holding-to-shift move.
// - rx full flag sets only on error-free character moved to rx holding.
// - rx full clears on reset, standby, read-1-then-write-0, or dma read.
// - overrun and rx disable leave rx holding data and rx full unchanged.
// - character ending while rx full sets overrun; old data kept, new dropped.
// - overrun, framing, parity clear on reset, standby, or read-1-then-write-0.
// - rx disable leaves overrun, framing and parity flags unchanged.
// - any error flag stops reception; synchronous mode also stops transmission.
// - async framing error when first stop bit samples as 0.
// - with two stop bits only the first is checked.
// - framing error still loads rx holding but does not set rx full.
// - async parity error when ones count mismatches selected parity; not flagged if the same character has a framing error.
// - parity error loads rx holding without setting rx full.
// - tx end sets on reset, standby, tx disable, or last bit with tx empty.
// - tx end clears whenever tx empty is cleared by software or dma write; a last bit with tx empty in the same cycle sets it instead.
// - tx end is read-only; writes ignored.
// - multiprocessor bit of received character captured in read-only status bit.
// - multiprocessor status reads 0 after init and follows received bit.
// - status register resets to 84h on reset and standby entry.
package ssf_pkg;
   localparam logic [11:0] SSF_ADDR_STATUS = 12'h000; // status flags
   localparam logic [11:0] SSF_ADDR_RXDATA = 12'h004; // rx holding data
   localparam logic [11:0] SSF_ADDR_CTRL = 12'h008; // enables and mode
   localparam logic [11:0] SSF_ADDR_TXDATA = 12'h00C; // tx holding data
   localparam logic [7:0] SSF_STATUS_RESET = 8'h84;
   localparam int SSF_BIT_TXE = 7;
   localparam int SSF_BIT_RXF = 6;
   localparam int SSF_BIT_ORN = 5;
   localparam int SSF_BIT_FER = 4;
   localparam int SSF_BIT_PER = 3;
   localparam int SSF_BIT_TX_END_FLAG = 2;
   localparam int SSF_BIT_MPB = 1;
   localparam int SSF_NUM_CLR = 5; // clearable flags: bits 7..3
   localparam int SSF_CLR_LSB = 3;
   localparam int SSF_CTRL_TE = 0;
   localparam int SSF_CTRL_RE = 1;
   localparam int SSF_CTRL_SYNC = 2;
   localparam int SSF_CTRL_ODD = 3;
   localparam int SSF_CTRL_PAR_EN = 4;
   localparam int SSF_CTRL_TWO_STOP = 5;
   localparam int SSF_CTRL_MP = 6;
   localparam logic [7:0] SSF_CTRL_RESET = 8'h00;
   localparam logic [7:0] SSF_CTRL_MASK = 8'h7F;
endpackage

/* File: rtl/ssf_clear_flag.sv */
// one clearable status flag with read-then-clear arming
`timescale 1ns/10ps
`default_nettype none
module ssf_clear_flag (
   input wire logic i_clk, // system clock
   input wire logic i_reset, // sync reset, high
   input wire logic i_init, // reset or standby force
   input wire logic i_init_val, // value taken on init
   input wire logic i_set, // hardware set event
   input wire logic i_hw_clr, // hardware clear event
   input wire logic i_rd, // status read strobe
   input wire logic i_wr, // status write strobe
   input wire logic i_wr_bit, // written bit value
   output logic o_flag, // flag value
   output logic o_sw_clr // software clear taking effect
);
   logic flag_r;
   logic armed_r;
   logic flag_nxt;
   logic armed_nxt;

   // write 0 honoured only when armed; write 1 ignored
   assign o_sw_clr = i_wr && !i_wr_bit && armed_r && flag_r;
   assign o_flag = flag_r;

   // set beats software and hardware clear; init beats set
   always_comb begin
      flag_nxt = flag_r;
      armed_nxt = armed_r;
      if (i_rd && flag_r) begin
         armed_nxt = 1'b1;
      end
      if (o_sw_clr || i_hw_clr) begin
         flag_nxt = 1'b0;
         armed_nxt = 1'b0;
      end
      if (i_set) begin
         flag_nxt = 1'b1;
      end
      if (!flag_nxt) begin
         armed_nxt = 1'b0;
      end
      if (i_init) begin
         flag_nxt = i_init_val;
         armed_nxt = 1'b0;
      end
   end

   // flag and arm state
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         flag_r <= 1'b0;
         armed_r <= 1'b0;
      end else begin
         flag_r <= flag_nxt;
         armed_r <= armed_nxt;
      end
   end
endmodule // ssf_clear_flag
`default_nettype wire

/* File: rtl/ssf_status.sv */
// serial status flags block with apb register access
//
// Added by the designer: the APB interface to the registers and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
module ssf_status (
   input wire logic i_clk, // 200 MHz system clock
   input wire logic i_reset, // sync reset, high
   input wire logic i_standby, // standby entry, re-inits flags
   input wire logic i_psel, // apb select
   input wire logic i_penable, // apb enable
   input wire logic i_pwrite, // apb direction
   input wire logic [11:0] i_paddr, // apb byte address
   input wire logic [31:0] i_pwdata, // apb write data
   output logic o_pready, // apb ready
   output logic [31:0] o_prdata, // apb read data
   output logic o_pslverr, // apb error
   input wire logic i_tx_load, // holding moved to shift reg
   input wire logic i_tx_last_bit, // last bit of character sent
   input wire logic i_rx_done, // receive frame end
   input wire logic [7:0] i_rx_data, // received character
   input wire logic i_rx_parity, // received parity bit
   input wire logic i_rx_stop1, // first stop bit sample
   input wire logic i_rx_stop2, // second stop bit sample
   input wire logic i_rx_mpb, // received multiproc bit
   input wire logic i_dma_rx_rd, // dma reads rx holding
   input wire logic i_dma_tx_wr, // dma writes tx holding
   input wire logic [7:0] i_dma_tx_data, // dma tx data
   output logic [7:0] o_tx_data, // tx holding register
   output logic o_tx_start, // tx holding has data, tx may run
   output logic o_rx_allow, // receiver may accept characters
   output logic o_tx_enable, // tx enable bit
   output logic o_rx_enable, // rx enable bit
   output logic o_sync_mode, // synchronous mode select
   output logic o_two_stop, // two stop bit format
   output logic o_tx_empty, // tx empty flag
   output logic o_rx_full, // rx full flag
   output logic o_tx_end // tx end flag
);
   logic [7:0] ctrl_r;
   logic [7:0] rx_hold_r;
   logic [7:0] tx_hold_r;
   logic tx_end_flag_r;
   logic mpb_r;
   logic [7:0] status;
   logic [ssf_pkg::SSF_NUM_CLR-1:0] flags;
   logic [ssf_pkg::SSF_NUM_CLR-1:0] set_ev;
   logic [ssf_pkg::SSF_NUM_CLR-1:0] hw_clr;
   logic [ssf_pkg::SSF_NUM_CLR-1:0] sw_clr;
   logic [ssf_pkg::SSF_NUM_CLR-1:0] init_val;
   logic [ssf_pkg::SSF_NUM_CLR-1:0] wr_bits;
   logic [31:0] rdata_nxt;

   // bus decode: every access completes in its first access cycle
   wire access = i_psel && i_penable;
   wire wr_en = access && i_pwrite;
   wire rd_en = access && !i_pwrite;
   wire hit_status = (i_paddr == ssf_pkg::SSF_ADDR_STATUS);
   wire hit_rxdata = (i_paddr == ssf_pkg::SSF_ADDR_RXDATA);
   wire hit_ctrl = (i_paddr == ssf_pkg::SSF_ADDR_CTRL);
   wire hit_txdata = (i_paddr == ssf_pkg::SSF_ADDR_TXDATA);
   wire hit_any = hit_status || hit_rxdata || hit_ctrl || hit_txdata;
   wire st_rd = rd_en && hit_status;
   wire st_wr = wr_en && hit_status;
   wire ctrl_wr = wr_en && hit_ctrl;
   wire init = i_reset || i_standby;
   assign o_pready = 1'b1;
   assign o_pslverr = access && !hit_any;

   // control fields
   wire te = ctrl_r[ssf_pkg::SSF_CTRL_TE];
   wire re = ctrl_r[ssf_pkg::SSF_CTRL_RE];
   wire sync_mode = ctrl_r[ssf_pkg::SSF_CTRL_SYNC];
   wire odd_par = ctrl_r[ssf_pkg::SSF_CTRL_ODD];
   wire par_en = ctrl_r[ssf_pkg::SSF_CTRL_PAR_EN];
   wire mp_fmt = ctrl_r[ssf_pkg::SSF_CTRL_MP];
   wire te_nxt = i_pwdata[ssf_pkg::SSF_CTRL_TE];
   wire te_clear = ctrl_wr && te && !te_nxt;

   // flag aliases
   wire txe = flags[ssf_pkg::SSF_BIT_TXE - ssf_pkg::SSF_CLR_LSB];
   wire rxf = flags[ssf_pkg::SSF_BIT_RXF - ssf_pkg::SSF_CLR_LSB];
   wire orn = flags[ssf_pkg::SSF_BIT_ORN - ssf_pkg::SSF_CLR_LSB];
   wire rx_framing_err_flag = flags[ssf_pkg::SSF_BIT_FER - ssf_pkg::SSF_CLR_LSB];
   wire rx_parity_err_flag = flags[ssf_pkg::SSF_BIT_PER - ssf_pkg::SSF_CLR_LSB];
   wire any_err = orn || rx_framing_err_flag || rx_parity_err_flag;

   // receive checks on a finished character
   wire rx_take = i_rx_done && re && !any_err;
   wire frame_err = !sync_mode && !i_rx_stop1;
   wire par_err = !sync_mode && par_en && ((^{i_rx_data, i_rx_parity}) != odd_par);
   wire overrun = rx_take && rxf;
   wire rx_good = rx_take && !rxf && !frame_err && !par_err;
   wire rx_load = rx_take && !rxf;
   wire tx_sw_clr = sw_clr[ssf_pkg::SSF_BIT_TXE - ssf_pkg::SSF_CLR_LSB];
   wire txe_clr = tx_sw_clr || i_dma_tx_wr;

   // per-flag set, clear and init terms, bit 0 is parity error
   assign set_ev = {
      i_tx_load || te_clear || !te,
      rx_good,
      overrun,
      rx_load && frame_err,
      rx_load && par_err && !frame_err
   };
   assign hw_clr = {i_dma_tx_wr, i_dma_rx_rd, 3'b000};
   assign init_val = ssf_pkg::SSF_STATUS_RESET[ssf_pkg::SSF_BIT_TXE:ssf_pkg::SSF_CLR_LSB];
   assign wr_bits = i_pwdata[ssf_pkg::SSF_BIT_TXE:ssf_pkg::SSF_CLR_LSB];

   // one clearable flag per bit
   genvar g;
   generate
      for (g = 0; g < ssf_pkg::SSF_NUM_CLR; g = g + 1) begin : g_flag
         ssf_clear_flag u_flag (
            .i_clk(i_clk),
            .i_reset(1'b0),
            .i_init(init),
            .i_init_val(init_val[g]),
            .i_set(set_ev[g]),
            .i_hw_clr(hw_clr[g]),
            .i_rd(st_rd),
            .i_wr(st_wr),
            .i_wr_bit(wr_bits[g]),
            .o_flag(flags[g]),
            .o_sw_clr(sw_clr[g])
         );
      end
   endgenerate

   // status image, reserved bit 0 reads zero
   assign status = {flags, tx_end_flag_r, mpb_r, 1'b0};

   // read data mux
   assign rdata_nxt = !hit_any ? 32'h0000_0000 :
                      hit_status ? {24'h000000, status} :
                      hit_rxdata ? {24'h000000, rx_hold_r} :
                      hit_ctrl ? {24'h000000, ctrl_r} : {24'h000000, tx_hold_r};
   assign o_prdata = rdata_nxt;

   // control register
   always_ff @(posedge i_clk) begin
      if (init) begin
         ctrl_r <= ssf_pkg::SSF_CTRL_RESET;
      end else if (ctrl_wr) begin
         ctrl_r <= i_pwdata[7:0] & ssf_pkg::SSF_CTRL_MASK;
      end
   end

   // tx end flag, read-only; set beats clear
   always_ff @(posedge i_clk) begin
      if (init) begin
         tx_end_flag_r <= ssf_pkg::SSF_STATUS_RESET[ssf_pkg::SSF_BIT_TX_END_FLAG];
      end else if (te_clear || !te || (i_tx_last_bit && txe)) begin
         tx_end_flag_r <= 1'b1;
      end else if (txe_clr) begin
         tx_end_flag_r <= 1'b0;
      end
   end

   // multiprocessor bit, read-only
   always_ff @(posedge i_clk) begin
      if (init) begin
         mpb_r <= ssf_pkg::SSF_STATUS_RESET[ssf_pkg::SSF_BIT_MPB];
      end else if (rx_load && mp_fmt && !sync_mode) begin
         mpb_r <= i_rx_mpb;
      end
   end

   // rx holding keeps old data on overrun
   always_ff @(posedge i_clk) begin
      if (init) begin
         rx_hold_r <= 8'h00;
      end else if (rx_load) begin
         rx_hold_r <= i_rx_data;
      end
   end

   // tx holding from bus or dma
   always_ff @(posedge i_clk) begin
      if (init) begin
         tx_hold_r <= 8'h00;
      end else if (i_dma_tx_wr) begin
         tx_hold_r <= i_dma_tx_data;
      end else if (wr_en && hit_txdata) begin
         tx_hold_r <= i_pwdata[7:0];
      end
   end

   // engine-facing outputs
   assign o_tx_data = tx_hold_r;
   assign o_tx_start = te && !txe && !(sync_mode && any_err);
   assign o_rx_allow = re && !any_err;
   assign o_tx_enable = te;
   assign o_rx_enable = re;
   assign o_sync_mode = sync_mode;
   assign o_two_stop = ctrl_r[ssf_pkg::SSF_CTRL_TWO_STOP];
   assign o_tx_empty = txe;
   assign o_rx_full = rxf;
   assign o_tx_end = tx_end_flag_r;
endmodule // ssf_status
`default_nettype wire

/* File: testbench/ssf_status_chk.sv */
// assertion checker for the serial status flag block
`timescale 1ns/10ps
`default_nettype none
module ssf_status_chk (
   input wire logic i_clk, // system clock
   input wire logic i_reset, // sync reset
   input wire logic i_standby, // standby entry
   input wire logic i_tx_load, // holding to shift move
   input wire logic i_tx_last_bit, // last bit sent
   input wire logic i_rx_done, // frame end
   input wire logic i_dma_rx_rd, // dma rx read
   input wire logic o_tx_enable, // tx enable bit
   input wire logic o_rx_allow, // receiver may accept
   input wire logic o_tx_empty, // tx empty flag
   input wire logic o_rx_full, // rx full flag
   input wire logic o_tx_end // tx end flag
);
   // reset or standby, both re-init the flags
   wire logic ini = i_reset | i_standby;
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_reset);
   // flag relations
   chk_txe_load: assert property (i_tx_load |=> o_tx_empty)
      else $error("tx empty not set after load");
   chk_tx_disable: assert property (!o_tx_enable |=> o_tx_empty && o_tx_end)
      else $error("tx flags not set while tx disabled");
   chk_rxf_dma: assert property (i_dma_rx_rd && !i_rx_done |=> !o_rx_full)
      else $error("rx full not cleared by dma read");
   chk_tx_end_flag_clr: assert property ($fell(o_tx_empty) && !$past(i_tx_last_bit) |-> !o_tx_end)
      else $error("tx end kept when tx empty cleared");
   chk_tx_end_flag_last: assert property (i_tx_last_bit && o_tx_empty |=> o_tx_end)
      else $error("tx end not set on last bit");
   chk_ovr_stop: assert property (i_rx_done && o_rx_allow && o_rx_full |=> !o_rx_allow)
      else $error("reception not stopped by overrun");
   chk_rxf_cause: assert property ($rose(o_rx_full) |-> $past(i_rx_done))
      else $error("rx full set without frame end");
   chk_init_val: assert property ($past(ini) |-> o_tx_empty && o_tx_end && !o_rx_full)
      else $error("flags wrong after reset or standby");
   // main scenarios reached
   cov_overrun: cover property (i_rx_done && o_rx_full);
   cov_tx_end_flag: cover property (i_tx_last_bit && o_tx_empty);
   cov_standby: cover property (i_standby);
endmodule // ssf_status_chk
`default_nettype wire

/* File: testbench/ssf_link_model.sv */
// far-side serial link model: frame-end and transmit events
`timescale 1ns/10ps
`default_nettype none
module ssf_link_model (
   input wire logic i_clk, // system clock
   output logic o_rx_done, // frame end pulse
   output logic [7:0] o_rx_data, // received character
   output logic o_rx_parity, // parity bit
   output logic o_rx_stop1, // first stop sample
   output logic o_rx_stop2, // second stop sample
   output logic o_rx_mpb, // multiproc bit
   output logic o_tx_load, // load pulse
   output logic o_tx_last_bit // last bit pulse
);
   // idle lines at time zero
   initial begin
      {o_rx_done, o_rx_data, o_rx_parity, o_rx_stop1, o_rx_stop2} = '0;
      {o_rx_mpb, o_tx_load, o_tx_last_bit} = '0;
   end
   // one frame end; lines flip afterwards so stale values never match
   task automatic rx_char(input logic [7:0] d, input logic p, s1, s2, m);
      o_rx_done <= 1'b1;
      {o_rx_data, o_rx_parity, o_rx_stop1, o_rx_stop2, o_rx_mpb} <= {d, p, s1, s2, m};
      @(posedge i_clk);
      o_rx_done <= 1'b0;
      {o_rx_data, o_rx_parity, o_rx_stop1, o_rx_stop2, o_rx_mpb} <= ~{d, p, s1, s2, m};
   endtask
   // one-cycle transmit events
   task automatic tx_evt(input logic l, b);
      {o_tx_load, o_tx_last_bit} <= {l, b};
      @(posedge i_clk);
      {o_tx_load, o_tx_last_bit} <= 2'b00;
   endtask
endmodule // ssf_link_model
`default_nettype wire

/* File: testbench/ssf_status_tb_top.sv */
// self-checking bench for the serial status flag block
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin fail_count++; \
   $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module ssf_status_tb_top;
   logic i_clk = 0, i_reset = 1, i_standby = 0, psel = 0, pen = 0, pwr = 0, drr = 0, dtw = 0;
   logic [11:0] pa = '0;
   logic [31:0] pwd = '0, rd;
   logic err;
   logic [7:0] dtd = '0;
   wire logic rdy, rxd, txl, txb, par, s1, s2, mp, tst, ral, txe, rxf, tnd, pse;
   wire logic [3:0] cfo; // two stop, sync, rx enable, tx enable
   wire logic [7:0] rxb, txd;
   wire logic [31:0] prd;
   int fail_count = 0, cmp_count = 0;
   // design and far side
   ssf_status u_dut (.i_clk(i_clk), .i_reset(i_reset), .i_standby(i_standby), .i_psel(psel),
      .i_penable(pen), .i_pwrite(pwr), .i_paddr(pa), .i_pwdata(pwd), .o_pready(rdy),
      .o_prdata(prd), .o_pslverr(pse), .i_tx_load(txl), .i_tx_last_bit(txb), .i_rx_done(rxd),
      .i_rx_data(rxb), .i_rx_parity(par), .i_rx_stop1(s1), .i_rx_stop2(s2), .i_rx_mpb(mp),
      .i_dma_rx_rd(drr), .i_dma_tx_wr(dtw), .i_dma_tx_data(dtd), .o_tx_data(txd),
      .o_tx_start(tst), .o_rx_allow(ral), .o_tx_enable(cfo[0]), .o_rx_enable(cfo[1]),
      .o_sync_mode(cfo[2]), .o_two_stop(cfo[3]), .o_tx_empty(txe), .o_rx_full(rxf),
      .o_tx_end(tnd));
   ssf_link_model u_link (.i_clk(i_clk), .o_rx_done(rxd), .o_rx_data(rxb), .o_rx_parity(par),
      .o_rx_stop1(s1), .o_rx_stop2(s2), .o_rx_mpb(mp), .o_tx_load(txl), .o_tx_last_bit(txb));
   initial forever #2.5 i_clk = ~i_clk;
   // one apb transfer, held until pready at the access edge
   task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
      {psel, pen, pwr, pa, pwd} <= {1'b1, 1'b0, w, a, 24'h0, d};
      @(posedge i_clk);
      pen <= 1'b1;
      do @(posedge i_clk); while (rdy !== 1'b1);
      rd = prd;
      err = pse;
      {psel, pen} <= 2'b00;
      // idle edge, so the next setup never re-drives psel in this step
      @(posedge i_clk);
   endtask
   task automatic rs(input logic [7:0] e);
      apb(1'b0, ssf_pkg::SSF_ADDR_STATUS, 8'h00);
      `CHK("status", {24'h0, e}, rd)
   endtask
   task automatic rx_holding_reg(input logic [7:0] e);
      apb(1'b0, ssf_pkg::SSF_ADDR_RXDATA, 8'h00);
      `CHK("rxdata", {24'h0, e}, rd)
   endtask
   // dma read, dma write and standby pulses
   task automatic ev(input logic [2:0] k, input logic [7:0] d);
      {drr, dtw, i_standby, dtd} <= {k, d};
      @(posedge i_clk);
      {drr, dtw, i_standby} <= 3'b000;
   endtask
   task automatic print_verdict;
      $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   initial begin
      #20000;
      fail_count++;
      print_verdict();
   end
   // main sequence
   initial begin
      repeat (16) @(posedge i_clk);
      i_reset <= 1'b0;
      rs(8'h84);
      apb(1'b1, ssf_pkg::SSF_ADDR_CTRL, 8'h53);
      u_link.rx_char(8'hA5, 1'b0, 1'b1, 1'b1, 1'b1);
      rs(8'hC6);
      rx_holding_reg(8'hA5);
      apb(1'b1, ssf_pkg::SSF_ADDR_STATUS, 8'hFF);
      rs(8'hC6);
      apb(1'b1, ssf_pkg::SSF_ADDR_CTRL, 8'h17);
      `CHK("ctrl", 4'h7, cfo)
      ev(3'b010, 8'h5A);
      #1 `CHK("txdata", 8'h5A, txd)
      @(posedge i_clk);
      u_link.rx_char(8'h3C, 1'b0, 1'b1, 1'b1, 1'b1);
      #1 `CHK("allow", 1'b0, ral)
      `CHK("start", 1'b0, tst)
      @(posedge i_clk);
      apb(1'b1, ssf_pkg::SSF_ADDR_CTRL, 8'h15);
      apb(1'b1, ssf_pkg::SSF_ADDR_STATUS, 8'hDF);
      rs(8'h62);
      rx_holding_reg(8'hA5);
      apb(1'b1, ssf_pkg::SSF_ADDR_STATUS, 8'hDF);
      rs(8'h42);
      ev(3'b100, 8'h00);
      rs(8'h02);
      u_link.tx_evt(1'b1, 1'b0);
      rs(8'h82);
      u_link.tx_evt(1'b0, 1'b1);
      rs(8'h86);
      apb(1'b1, ssf_pkg::SSF_ADDR_CTRL, 8'h53);
      u_link.rx_char(8'h55, 1'b0, 1'b0, 1'b1, 1'b1);
      rs(8'h96);
      rx_holding_reg(8'h55);
      apb(1'b1, ssf_pkg::SSF_ADDR_STATUS, 8'hEF);
      rs(8'h86);
      u_link.rx_char(8'h07, 1'b0, 1'b1, 1'b1, 1'b1);
      rs(8'h8E);
      rx_holding_reg(8'h07);
      apb(1'b1, ssf_pkg::SSF_ADDR_STATUS, 8'hF7);
      rs(8'h86);
      apb(1'b1, ssf_pkg::SSF_ADDR_CTRL, 8'h7B);
      `CHK("ctrl", 4'hB, cfo)
      u_link.rx_char(8'h07, 1'b0, 1'b1, 1'b0, 1'b0);
      rs(8'hC4);
      apb(1'b1, ssf_pkg::SSF_ADDR_STATUS, 8'hBF);
      rs(8'h84);
      ev(3'b010, 8'hC3);
      u_link.tx_evt(1'b1, 1'b0);
      rs(8'h80);
      fork
         apb(1'b1, ssf_pkg::SSF_ADDR_STATUS, 8'h7F);
         begin
            @(posedge i_clk);
            u_link.tx_evt(1'b1, 1'b0);
         end
      join
      rs(8'h80);
      u_link.tx_evt(1'b0, 1'b1);
      rs(8'h84);
      apb(1'b1, ssf_pkg::SSF_ADDR_STATUS, 8'h7F);
      rs(8'h00);
      apb(1'b1, ssf_pkg::SSF_ADDR_CTRL, 8'h12);
      rs(8'h84);
      apb(1'b0, 12'h010, 8'h00);
      `CHK("unmapped", 32'h0, rd)
      `CHK("slverr", 1'b1, err)
      u_link.rx_char(8'h81, 1'b0, 1'b1, 1'b1, 1'b1);
      rs(8'hC4);
      ev(3'b001, 8'h00);
      rs(8'h84);
      print_verdict();
   end
endmodule // ssf_status_tb_top
bind ssf_status ssf_status_chk u_chk (.i_clk, .i_reset, .i_standby, .i_tx_load, .i_tx_last_bit,
   .i_rx_done, .i_dma_rx_rd, .o_tx_enable, .o_rx_allow, .o_tx_empty, .o_rx_full, .o_tx_end);
`default_nettype wire
